// ### verilog/clock_position_capture.v
// Clock position capture window with its Avalon-MM register slave.
//
// Behaviour
// RQ1: Record input-clock rising edges relative to a request rising edge in read-only snapshot.
// RQ2: Snapshot fills from bit 0 upward, bit order follows increasing sample delay.
// RQ3: Each bit is one input-clock sample spaced by the selected step size.
// RQ4: Lowest and highest snapshot bits always read as one; the code reads both as zero from reset until the first capture.
// RQ5: Each adjacent pair of set bits, boundaries included, marks a rising edge.
// RQ6: Snapshot is 32 bits; low half at one register, high half at next.
// RQ7: Step code 0..3 gives 28, 15, 11, 8 ps; resets to code 3.
// RQ8: Selected step drives both request input delay and capture sample spacing.
// RQ9: Software picks the step whose frequency range holds the input-clock frequency.
// RQ10: In overlapping ranges software prefers the larger step size.
// RQ11: Software computes request delay from edge positions, clock period and step.
// RQ12: Step register bits 15 to 2 are written zero and read-only.
// RQ13: Before each capture the request-latch clear is driven high then low.
// RQ14: First request rising edge after clearing triggers capture if capture enable set.
// RQ15: Capture enable ignored while both sync and alignment path enables are zero.
// RQ16: Snapshot resets to zero and holds until the next triggered capture completes.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "clock_position_capture_regs.vh"

module clock_position_capture (
	input wire sys_clk_i, // 40 MHz system clock
	input wire sys_rst_i, // Asynchronous reset, active high
	input wire [9:0] avs_address_i, // Avalon byte address
	input wire avs_read_i, // Avalon read request
	input wire avs_write_i, // Avalon write request
	input wire [31:0] avs_writedata_i, // Avalon write data
	input wire [3:0] avs_byteenable_i, // Avalon byte enables
	output wire [31:0] avs_readdata_o, // Avalon read data
	output wire avs_waitrequest_o, // Avalon wait request
	input wire alignment_request_input_i, // Alignment request pin, asynchronous
	input wire [31:0] tap_samples_i, // Input clock sampled at the 32 delay taps
	output wire [1:0] request_delay_step_o, // Tap spacing to the delay line
	output wire capture_window_en_o // Powers the windowing circuit
);

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_CLEARING = 3'b010;
	localparam [2:0] ST_ARMED = 3'b100;

	reg [2:0] req_sync_q;
	reg req_level_q;
	reg req_level_d;
	reg [31:0] tap_s1_q;
	reg [31:0] tap_s2_q;
	reg [31:0] tap_s3_q;
	reg [31:0] tap_level_q;
	reg [31:0] snapshot_q;
	reg [1:0] step_q;
	reg [3:0] ctrl_q;
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg wait_q;
	reg [31:0] rdata_q;
	reg [31:0] rdata_d;
	reg window_en_q;
	wire req_rise;
	wire window_en;
	wire [31:0] tap_agree;
	wire bus_req;
	wire wr_take;

	// Pin inputs pass three flops; a change counts once the second and third agree.
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			req_sync_q <= 3'h0;
			req_level_q <= 1'b0;
			tap_s1_q <= 32'h0000_0000;
			tap_s2_q <= 32'h0000_0000;
			tap_s3_q <= 32'h0000_0000;
			tap_level_q <= 32'h0000_0000;
		end else begin
			req_sync_q <= {req_sync_q[1:0], alignment_request_input_i};
			req_level_q <= req_level_d;
			tap_s1_q <= tap_samples_i;
			tap_s2_q <= tap_s1_q;
			tap_s3_q <= tap_s2_q;
			tap_level_q <= (tap_s3_q & tap_agree) | (tap_level_q & ~tap_agree);
		end
	end

	assign tap_agree = ~(tap_s2_q ^ tap_s3_q);

	always @* begin
		req_level_d = req_level_q;
		if (req_sync_q[1] == req_sync_q[2]) begin
			req_level_d = req_sync_q[2];
		end
	end

	assign req_rise = req_level_d & ~req_level_q;

	// Without either path enable the capture enable has no effect. [RQ15]
	assign window_en = ctrl_q[`CTRL_CAPTURE_EN_BIT] &
		(ctrl_q[`CTRL_SYNC_EN_BIT] | ctrl_q[`CTRL_ALIGN_EN_BIT]);

	// Arming needs the clear bit seen high and then low. [RQ13]
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (ctrl_q[`CTRL_LATCH_CLEAR_BIT]) begin
					state_d = ST_CLEARING;
				end
			end
			ST_CLEARING: begin
				if (!ctrl_q[`CTRL_LATCH_CLEAR_BIT]) begin
					state_d = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (ctrl_q[`CTRL_LATCH_CLEAR_BIT]) begin
					state_d = ST_CLEARING;
				end else if (req_rise && window_en) begin
					state_d = ST_IDLE; // [RQ14]
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Bit 0 is the shortest tap delay, so the pattern keeps delay order upward. [RQ2] [RQ3]
	// The two window bits are forced set because their neighbours lie outside the window. [RQ4] [RQ5]
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= ST_IDLE;
			snapshot_q <= `SNAPSHOT_RESET;
			window_en_q <= 1'b0;
		end else begin
			state_q <= state_d;
			window_en_q <= window_en;
			if (state_q == ST_ARMED && !ctrl_q[`CTRL_LATCH_CLEAR_BIT] && req_rise && window_en) begin
				snapshot_q <= {1'b1, tap_level_q[30:1], 1'b1}; // [RQ1] [RQ16]
			end
		end
	end

	// One wait cycle: waitrequest drops the cycle after a request is seen.
	assign bus_req = avs_read_i | avs_write_i;
	assign wr_take = avs_write_i & ~wait_q;

	always @* begin
		rdata_d = 32'h0000_0000;
		case (avs_address_i)
			`SNAPSHOT_LOW_ADDR: begin
				rdata_d = {16'h0000, snapshot_q[15:0]}; // [RQ6]
			end
			`SNAPSHOT_HIGH_ADDR: begin
				rdata_d = {16'h0000, snapshot_q[31:16]}; // [RQ6]
			end
			`STEP_CONFIG_ADDR: begin
				rdata_d = {30'h0000_0000, step_q}; // [RQ12]
			end
			`CAPTURE_CTRL_ADDR: begin
				rdata_d = {28'h000_0000, ctrl_q};
			end
			default: begin
				rdata_d = 32'h0000_0000;
			end
		endcase
	end

	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			step_q <= `STEP_RESET; // [RQ7]
			ctrl_q <= `CTRL_RESET;
		end else begin
			if (bus_req && wait_q) begin
				wait_q <= 1'b0;
				rdata_q <= rdata_d;
			end else begin
				wait_q <= 1'b1;
			end
			// Only the step field is writable; upper bits are dropped. [RQ12] [RQ7]
			if (wr_take && avs_address_i == `STEP_CONFIG_ADDR && avs_byteenable_i[0]) begin
				step_q <= avs_writedata_i[`STEP_MSB:`STEP_LSB];
			end
			if (wr_take && avs_address_i == `CAPTURE_CTRL_ADDR && avs_byteenable_i[0]) begin
				ctrl_q <= avs_writedata_i[3:0];
			end
		end
	end

	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = wait_q;
	// The same step code feeds the request delay and the capture tap spacing. [RQ8]
	assign request_delay_step_o = step_q;
	assign capture_window_en_o = window_en_q;

endmodule

`default_nettype wire

// ### verilog/clock_position_capture_regs.vh
// Register map, field positions and reset values of the clock position capture block.
`ifndef CLOCK_POSITION_CAPTURE_REGS_VH
`define CLOCK_POSITION_CAPTURE_REGS_VH

// Register indices as printed; the byte address is four times the index.
`define SNAPSHOT_LOW_INDEX 8'h0b
`define SNAPSHOT_HIGH_INDEX 8'h0c
`define STEP_CONFIG_INDEX 8'h0d
`define CAPTURE_CTRL_INDEX 8'h10

`define SNAPSHOT_LOW_ADDR 10'h02c
`define SNAPSHOT_HIGH_ADDR 10'h030
`define STEP_CONFIG_ADDR 10'h034
`define CAPTURE_CTRL_ADDR 10'h040

// Step-size field and its codes.
`define STEP_LSB 0
`define STEP_MSB 1
`define STEP_RESET 2'h3
`define STEP_28PS 2'h0
`define STEP_15PS 2'h1
`define STEP_11PS 2'h2
`define STEP_8PS 2'h3

// Capture control register bit positions.
`define CTRL_CAPTURE_EN_BIT 0
`define CTRL_LATCH_CLEAR_BIT 1
`define CTRL_ALIGN_EN_BIT 2
`define CTRL_SYNC_EN_BIT 3
`define CTRL_RESET 4'h0

`define SNAPSHOT_RESET 32'h0000_0000
`define SNAPSHOT_WIDTH 32

`endif

// ### verification/clock_position_capture_assertions.sv
// Port checker of the clock position capture block.
`timescale 1ns/1ps
`default_nettype none
module clock_position_capture_assertions (
	input wire sys_clk_i, // clock
	input wire sys_rst_i, // reset
	input wire [9:0] avs_address_i, // address
	input wire avs_read_i, // read
	input wire avs_write_i, // write
	input wire [31:0] avs_readdata_o, // read data
	input wire avs_waitrequest_o, // wait
	input wire [1:0] request_delay_step_o, // step
	input wire capture_window_en_o // window
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	wire done = !avs_waitrequest_o;
	wire wr34 = avs_write_i && done && avs_address_i == 10'h034;
	wire wr40 = avs_write_i && done && avs_address_i == 10'h040;
	wire rd34 = avs_read_i && done && avs_address_i == 10'h034;
	wire rdsn = avs_read_i && done && (avs_address_i == 10'h02c || avs_address_i == 10'h030);
	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	a_wait_answer: assert property (s_req |=> done) else $error("no answer");
	a_wait_single: assert property (done |=> !done) else $error("wait low twice");
	a_wait_cause: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i)) else $error("idle answer");
	a_step_reset: assert property ($past(sys_rst_i) |-> request_delay_step_o == 2'h3) else $error("step reset");
	a_step_write: assert property ($changed(request_delay_step_o) |-> $past(wr34)) else $error("step moved");
	a_step_read: assert property (rd34 |-> avs_readdata_o == {30'h0, request_delay_step_o}) else $error("step read");
	a_snap_upper: assert property (rdsn |-> avs_readdata_o[31:16] == 16'h0) else $error("snap width");
	a_window_cause: assert property ($changed(capture_window_en_o) |-> $past(wr40) || $past(wr40, 2)) else $error("window");
endmodule
bind clock_position_capture clock_position_capture_assertions u_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .request_delay_step_o(request_delay_step_o),
	.capture_window_en_o(capture_window_en_o));
`default_nettype wire

// ### verification/request_source_model.sv
// Source of the alignment request pin and of the tap samples.
`timescale 1ns/1ps
`default_nettype none
module request_source_model (
	input wire logic sys_clk_i, // clock
	output logic request_o, // request pin
	output logic [31:0] taps_o // clock seen at taps, bit 0 shortest delay
);
	initial begin
		request_o = 1'b0;
		taps_o = 32'h0;
	end
	// Taps settle first, since the pin passes a synchroniser.
	task automatic fire(input logic [31:0] p);
		@(posedge sys_clk_i) taps_o <= p;
		repeat (5) @(posedge sys_clk_i);
		request_o <= 1'b1;
		repeat (6) @(posedge sys_clk_i);
		request_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench of the clock position capture block.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [9:0] adr = 10'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] got;
	wire [31:0] rdat;
	wire [31:0] taps;
	wire [1:0] step;
	wire wreq;
	wire win;
	wire req;
	int errors = 0;
	int check_count = 0;
	always #12.5 sys_clk_i = ~sys_clk_i;
	clock_position_capture u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .alignment_request_input_i(req), .tap_samples_i(taps),
		.request_delay_step_o(step), .capture_window_en_o(win));
	request_source_model u_src (.sys_clk_i(sys_clk_i), .request_o(req), .taps_o(taps));
	task automatic end_sim;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask
	// The request is held until the rising edge at which waitrequest is seen low.
	task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk_i);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		if (n >= 50) begin
			chk("waitrequest", 32'h0, {31'h0, wreq});
			end_sim();
		end
		got = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic snap(input logic [31:0] e);
		xfer(0, 10'h02c, 0);
		chk("snap_low", {16'h0, e[15:0]}, got);
		xfer(0, 10'h030, 0);
		chk("snap_high", {16'h0, e[31:16]}, got);
	endtask
	task automatic arm(input logic [31:0] p);
		xfer(1, 10'h040, 32'h7);
		xfer(1, 10'h040, 32'h5);
		u_src.fire(p);
		repeat (8) @(posedge sys_clk_i);
	endtask
	initial begin
		repeat (12) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		snap(32'h0);
		xfer(0, 10'h034, 0);
		chk("step_reset", 32'h3, got);
		// Software picks a step code per clock frequency; every code is exercised.
		for (int c = 0; c < 4; c++) begin
			xfer(1, 10'h034, 32'hffff_fffc | c);
			xfer(0, 10'h034, 0);
			chk("step_reg", c, got);
			chk("step_pin", c, {30'h0, step});
		end
		xfer(1, 10'h02c, 32'hffff_ffff);
		snap(32'h0);
		arm(32'h3c3c_3c3c);
		snap(32'hbc3c_3c3d);
		chk("window_on", 1, {31'h0, win});
		u_src.fire(32'h0);
		repeat (8) @(posedge sys_clk_i);
		snap(32'hbc3c_3c3d);
		arm(32'h4387_0e1c);
		snap(32'hc387_0e1d);
		xfer(1, 10'h040, 32'h1);
		xfer(0, 10'h040, 0);
		chk("window_off", 0, {31'h0, win});
		xfer(1, 10'h040, 32'h9);
		xfer(0, 10'h040, 0);
		chk("window_sync", 1, {31'h0, win});
		end_sim();
	end
endmodule
`default_nettype wire
